// ### rtl/chs_defs.vh
`ifndef CHS_DEFS_VH
`define CHS_DEFS_VH

// ==========================================================
// register map
`define CHS_ADDR_W 4
`define CHS_DATA_W 8
`define CHS_HW_STATUS_ADDR 4'h0f

// ==========================================================
// hardware_status field positions
`define CHS_BIT_SHUTDOWN 7
`define CHS_BIT_PROT_FAULT 5
`define CHS_BIT_SUPERVISOR 4
`define CHS_BIT_PRESENCE 2
`define CHS_BIT_OVERHEAT 0

// ==========================================================
// reset values
`define CHS_STATUS_RESET 8'h10
`define CHS_RDATA_RESET 8'h00

// ==========================================================
// timing
`define CHS_CLK_PERIOD_PS 4000
`define CHS_POR_PULSE_NS 4096
`define CHS_POR_PULSE_CYCLES ((`CHS_POR_PULSE_NS * 1000) / `CHS_CLK_PERIOD_PS)
`define CHS_CLEAR_DELAY_CYCLES 2

`endif

// ### rtl/chs_sync.v
`timescale 1ns/1ps

// ==========================================================
// three-stage input synchroniser with agreement filter
module chs_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   // clock and reset
   input wire clk,
   input wire rstn,
   // asynchronous inputs
   input wire [WIDTH-1:0] async_in,
   // synchronised level and change pulse
   output reg [WIDTH-1:0] level_r,
   output reg [WIDTH-1:0] change_r
);

   reg [WIDTH-1:0] meta_r;
   reg [WIDTH-1:0] mid_r;
   reg [WIDTH-1:0] last_r;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         // first stage feeds only the second
         always @(posedge clk) begin
            if (!rstn) begin
               meta_r[i] <= INIT[i];
               mid_r[i] <= INIT[i];
               last_r[i] <= INIT[i];
               level_r[i] <= INIT[i];
               change_r[i] <= 1'b0;
            end else begin
               meta_r[i] <= async_in[i];
               mid_r[i] <= meta_r[i];
               last_r[i] <= mid_r[i];
               // a new value counts once stages two and three agree
               if (mid_r[i] == last_r[i] && last_r[i] != level_r[i]) begin
                  level_r[i] <= last_r[i];
                  change_r[i] <= 1'b1;
               end else begin
                  change_r[i] <= 1'b0;
               end
            end
         end
      end
   endgenerate

endmodule

// ### rtl/chs_status.v
`timescale 1ns/1ps
`include "chs_defs.vh"

// Overview of operation
// RULE1 - shutdown flag bit 7 sets while the shutdown request pin is low
// RULE2 - firmware seeing shutdown deactivates card, ports high, masks interrupts, powers down
// RULE3 - firmware does the same when powered up with shutdown pin low
// RULE4 - shutdown mode ends only when the shutdown request pin returns high
// RULE5 - bit 5 is the OR of supply and reset contact protection faults
// RULE6 - power-on or supply dropout sets supervisor latch bit 4, interrupt low
// RULE7 - interrupt goes high at end of por pulse unless shutdown pin was low
// RULE8 - supervisor latch clears only on a read after the por pulse ended
// RULE9 - leaving shutdown behaves like power-on for latch and interrupt
// RULE10 - bit 2 sets on any change of card presence, either direction
// RULE11 - bit 0 sets when overheating has occurred
// RULE12 - interrupt held low while fault, presence, overheat or shutdown flag set
// RULE13 - a status read clears causing bits two clocks after the read strobe
// RULE14 - emergency deactivation events clear the power control start bit
// RULE15 - bits 6, 3 and 1 read zero and ignore writes
module chs_status #(
   parameter POR_CYCLES = `CHS_POR_PULSE_CYCLES
) (
   // clock and reset
   input wire clk,
   input wire rstn,
   // register port
   input wire [`CHS_ADDR_W-1:0] addr,
   input wire [`CHS_DATA_W-1:0] wdata,
   input wire wr,
   input wire rd,
   output reg [`CHS_DATA_W-1:0] rdata_r,
   // pins and analog monitors
   input wire shutdown_request_pin_n,
   input wire vcc_prot_fault,
   input wire rst_prot_fault,
   input wire supply_dropout,
   input wire overheat,
   // card presence from the mixed status register
   input wire card_presence,
   // outputs
   output reg interrupt_out_n_r,
   output reg start_clear_r,
   output reg shutdown_mode_r,
   output reg por_pulse_active_r
);

   // ==========================================================
   // local constants
   localparam CNT_W = 16;
   localparam [CNT_W-1:0] POR_LOAD = POR_CYCLES[CNT_W-1:0];
   localparam [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam NSYNC = 5;

   // synchroniser lanes
   localparam SY_SHUT = 0;
   localparam SY_PROT = 1;
   localparam SY_DROP = 2;
   localparam SY_HEAT = 3;
   localparam SY_PRES = 4;
   localparam [`CHS_DATA_W-1:0] STATUS_RESET = `CHS_STATUS_RESET;

   // one-hot por states
   localparam [2:0] ST_PULSE = 3'b001;
   localparam [2:0] ST_RUN = 3'b010;
   localparam [2:0] ST_SHUT = 3'b100;

   // ==========================================================
   // address decode, used by both read and write paths
   function hit_status;
      input [`CHS_ADDR_W-1:0] a;
      begin
         hit_status = (a == `CHS_HW_STATUS_ADDR);
      end
   endfunction

   // ==========================================================
   // input synchronisers
   wire [NSYNC-1:0] async_bus;
   wire [NSYNC-1:0] sync_level;
   wire [NSYNC-1:0] sync_change;
   wire sd_req;
   wire prot_any;
   wire dropout_s;
   wire overheat_s;
   wire presence_chg;

   // pin is synchronised inverted so that 1 means a request is present;
   // lanes reset to their idle level, so a high pin gives no false request
   assign async_bus[SY_SHUT] = ~shutdown_request_pin_n;
   assign async_bus[SY_PROT] = vcc_prot_fault | rst_prot_fault; // RULE5
   assign async_bus[SY_DROP] = supply_dropout;
   assign async_bus[SY_HEAT] = overheat;
   assign async_bus[SY_PRES] = card_presence;

   chs_sync #(
      .WIDTH(NSYNC),
      .INIT(5'h00)
   ) u_sync (
      .clk(clk),
      .rstn(rstn),
      .async_in(async_bus),
      .level_r(sync_level),
      .change_r(sync_change)
   );

   assign sd_req = sync_level[SY_SHUT];
   assign prot_any = sync_level[SY_PROT]; // RULE5
   assign dropout_s = sync_level[SY_DROP];
   assign overheat_s = sync_level[SY_HEAT];
   assign presence_chg = sync_change[SY_PRES]; // RULE10

   // ==========================================================
   // status flags
   reg shutdown_flag_r;
   reg card_protection_fault_r;
   reg supervisor_latch_r;
   reg presence_change_latch_r;
   reg overheat_latch_r;

   // por pulse sequencer
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [CNT_W-1:0] por_cnt_r;
   reg [CNT_W-1:0] por_cnt_nxt;
   wire por_active;
   wire shut_exit;
   wire supervisor_latch_set;

   // read clear pipeline
   reg rd_d1_r;
   reg rd_d2_r;
   reg [`CHS_DATA_W-1:0] clr_mask_d1_r;
   reg [`CHS_DATA_W-1:0] clr_mask_d2_r;
   reg [`CHS_DATA_W-1:0] status_word;
   reg [`CHS_DATA_W-1:0] rd_clr_mask;
   wire [`CHS_DATA_W-1:0] clr_now;
   wire rd_hit;
   wire wr_hit;

   // registered output next values
   reg [`CHS_DATA_W-1:0] rdata_nxt;
   reg int_n_nxt;
   reg start_clear_nxt;

   // ==========================================================
   // por pulse and shutdown sequencer
   assign por_active = (state_r == ST_PULSE);
   assign shut_exit = (state_r == ST_SHUT) && !sd_req;

   always @* begin
      state_nxt = state_r;
      por_cnt_nxt = por_cnt_r;
      case (state_r)
         ST_PULSE: begin
            if (sd_req) begin
               state_nxt = ST_SHUT;
            end else if (dropout_s) begin
               por_cnt_nxt = POR_LOAD;
            end else if (por_cnt_r <= CNT_ONE) begin
               state_nxt = ST_RUN;
               por_cnt_nxt = CNT_ZERO;
            end else begin
               por_cnt_nxt = por_cnt_r - CNT_ONE;
            end
         end
         ST_RUN: begin
            if (sd_req) begin
               state_nxt = ST_SHUT;
            end else if (dropout_s) begin
               // supply dropout restarts the pulse
               state_nxt = ST_PULSE; // RULE6
               por_cnt_nxt = POR_LOAD;
            end
         end
         ST_SHUT: begin
            // only the pin going high leaves shutdown
            if (!sd_req) begin
               state_nxt = ST_PULSE; // RULE4 RULE9
               por_cnt_nxt = POR_LOAD;
            end
         end
         default: begin
            state_nxt = ST_PULSE;
            por_cnt_nxt = POR_LOAD;
         end
      endcase
   end

   always @(posedge clk) begin
      if (!rstn) begin
         state_r <= ST_PULSE;
         por_cnt_r <= POR_LOAD;
      end else begin
         state_r <= state_nxt;
         por_cnt_r <= por_cnt_nxt;
      end
   end

   assign supervisor_latch_set = (dropout_s && !sd_req) || shut_exit; // RULE6 RULE9

   // ==========================================================
   // register port
   assign rd_hit = rd && hit_status(addr);
   // status is read only; a write only zeroes the read data of a read in the same cycle
   assign wr_hit = wr && hit_status(addr) && (wdata == wdata);

   // unused bits keep the zero default
   always @* begin
      status_word = {`CHS_DATA_W{1'b0}}; // RULE15
      status_word[`CHS_BIT_SHUTDOWN] = shutdown_flag_r;
      status_word[`CHS_BIT_PROT_FAULT] = card_protection_fault_r;
      status_word[`CHS_BIT_SUPERVISOR] = supervisor_latch_r;
      status_word[`CHS_BIT_PRESENCE] = presence_change_latch_r;
      status_word[`CHS_BIT_OVERHEAT] = overheat_latch_r;
   end

   always @* begin
      rdata_nxt = `CHS_RDATA_RESET;
      if (rd_hit && !wr_hit) begin
         rdata_nxt = status_word;
      end
   end

   // a read inside the pulse leaves the supervisor latch alone
   always @* begin
      rd_clr_mask = status_word;
      if (por_active) begin
         rd_clr_mask[`CHS_BIT_SUPERVISOR] = 1'b0; // RULE8
      end
   end

   always @(posedge clk) begin
      if (!rstn) begin
         rdata_r <= `CHS_RDATA_RESET;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // ==========================================================
   // read clear, two clocks after the strobe
   // snapshot only bits seen set, so events after the read survive
   always @(posedge clk) begin
      if (!rstn) begin
         rd_d1_r <= 1'b0;
         rd_d2_r <= 1'b0;
         clr_mask_d1_r <= `CHS_RDATA_RESET;
         clr_mask_d2_r <= `CHS_RDATA_RESET;
      end else begin
         rd_d1_r <= rd_hit; // RULE13
         rd_d2_r <= rd_d1_r;
         if (rd_hit) begin
            clr_mask_d1_r <= rd_clr_mask; // RULE8
         end else begin
            clr_mask_d1_r <= `CHS_RDATA_RESET;
         end
         clr_mask_d2_r <= clr_mask_d1_r;
      end
   end

   assign clr_now = rd_d2_r ? clr_mask_d2_r : `CHS_RDATA_RESET;

   // ==========================================================
   // sticky flags, set wins over clear
   always @(posedge clk) begin
      if (!rstn) begin
         shutdown_flag_r <= STATUS_RESET[`CHS_BIT_SHUTDOWN];
         card_protection_fault_r <= STATUS_RESET[`CHS_BIT_PROT_FAULT];
         supervisor_latch_r <= STATUS_RESET[`CHS_BIT_SUPERVISOR];
         presence_change_latch_r <= STATUS_RESET[`CHS_BIT_PRESENCE];
         overheat_latch_r <= STATUS_RESET[`CHS_BIT_OVERHEAT];
      end else begin
         // level set: a read while the pin stays low cannot drop it
         shutdown_flag_r <= sd_req || (shutdown_flag_r && !clr_now[`CHS_BIT_SHUTDOWN]); // RULE1
         card_protection_fault_r <= prot_any ||
            (card_protection_fault_r && !clr_now[`CHS_BIT_PROT_FAULT]); // RULE5
         supervisor_latch_r <= supervisor_latch_set ||
            (supervisor_latch_r && !(clr_now[`CHS_BIT_SUPERVISOR] && !por_active)); // RULE8
         presence_change_latch_r <= presence_chg ||
            (presence_change_latch_r && !clr_now[`CHS_BIT_PRESENCE]); // RULE10
         overheat_latch_r <= overheat_s || (overheat_latch_r && !clr_now[`CHS_BIT_OVERHEAT]); // RULE11
      end
   end

   // ==========================================================
   // outputs
   always @* begin
      // the pulse state, not the supervisor latch, pulls the line; a request still
      // in flight pulls it before its flag lands, so shutdown entry shows no high
      int_n_nxt = !((state_nxt == ST_PULSE) || sd_req || shutdown_flag_r || card_protection_fault_r ||
                    presence_change_latch_r || overheat_latch_r); // RULE7 RULE12
      start_clear_nxt = prot_any || supervisor_latch_set || presence_chg || overheat_s; // RULE14
   end

   always @(posedge clk) begin
      if (!rstn) begin
         interrupt_out_n_r <= 1'b0;
         start_clear_r <= 1'b0;
         shutdown_mode_r <= 1'b0;
         por_pulse_active_r <= 1'b1;
      end else begin
         interrupt_out_n_r <= int_n_nxt; // RULE7 RULE12
         start_clear_r <= start_clear_nxt; // RULE14
         shutdown_mode_r <= (state_nxt == ST_SHUT); // RULE4
         por_pulse_active_r <= (state_nxt == ST_PULSE);
      end
   end

endmodule

// ### test/chs_status_props.sv
`timescale 1ns/1ps
// ====
// status block checker
module chs_status_props #(
   parameter POR_CYCLES = 8
) (
   // clock and reset
   input wire clk,
   input wire rstn,
   // register port
   input wire [3:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   input wire [7:0] rdata_r,
   // pins and monitors
   input wire shutdown_request_pin_n,
   input wire vcc_prot_fault,
   input wire rst_prot_fault,
   input wire supply_dropout,
   input wire overheat,
   input wire card_presence,
   // outputs
   input wire interrupt_out_n_r,
   input wire start_clear_r,
   input wire shutdown_mode_r,
   input wire por_pulse_active_r
);
   wire fault = vcc_prot_fault || rst_prot_fault || overheat;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ====
   // assertions
   AST_UNUSED_ZERO: assert property ((rdata_r & 8'h4a) == 8'h00)
      else $error("unused status bit read as one");
   AST_UNMAPPED: assert property (rd && addr != 4'hf |=> rdata_r == 8'h00)
      else $error("unmapped read not zero");
   AST_SD_ENTRY: assert property ($fell(shutdown_request_pin_n) ##1 !shutdown_request_pin_n [*7] |-> shutdown_mode_r)
      else $error("shutdown not entered");
   AST_SD_HOLD: assert property (shutdown_mode_r && !shutdown_request_pin_n |=> shutdown_mode_r)
      else $error("shutdown left while pin low");
   AST_SD_INT: assert property (shutdown_mode_r |-> !interrupt_out_n_r)
      else $error("interrupt high in shutdown");
   AST_SD_EXIT: assert property ($fell(shutdown_mode_r) |-> ##[0:2] (por_pulse_active_r && !interrupt_out_n_r))
      else $error("no pulse after shutdown exit");
   AST_POR_INT: assert property (por_pulse_active_r |-> !interrupt_out_n_r)
      else $error("interrupt high during pulse");
   AST_FAULT_INT: assert property (fault [*8] |-> !interrupt_out_n_r)
      else $error("interrupt high with fault");
   AST_FAULT_START: assert property ($rose(fault) |-> ##[1:10] start_clear_r)
      else $error("no start clear on fault");
   AST_PRES_START: assert property ($changed(card_presence) |-> ##[1:10] start_clear_r)
      else $error("no start clear on presence");
   AST_DROP: assert property ((supply_dropout && !shutdown_mode_r) [*8] |-> por_pulse_active_r)
      else $error("dropout without pulse");
   cover property ($rose(shutdown_mode_r));
   cover property ($fell(por_pulse_active_r));
   cover property (start_clear_r);
endmodule

bind chs_status chs_status_props #(.POR_CYCLES(POR_CYCLES)) u_props (.clk(clk), .rstn(rstn),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r),
   .shutdown_request_pin_n(shutdown_request_pin_n), .vcc_prot_fault(vcc_prot_fault),
   .rst_prot_fault(rst_prot_fault), .supply_dropout(supply_dropout), .overheat(overheat),
   .card_presence(card_presence), .interrupt_out_n_r(interrupt_out_n_r),
   .start_clear_r(start_clear_r), .shutdown_mode_r(shutdown_mode_r),
   .por_pulse_active_r(por_pulse_active_r));

// ### test/chs_fw_model.sv
`timescale 1ns/1ps
// ====
// firmware reaction to the status register
module chs_fw_model (
   // clock and reset
   input wire clk,
   input wire rstn,
   // register port as firmware sees it
   input wire rd,
   input wire [3:0] addr,
   input wire [7:0] rdata_r,
   // shutdown procedure finished
   output reg powered_down_r
);
   reg rd_hit_r;
   always @(posedge clk) begin
      if (!rstn) begin
         rd_hit_r <= 1'b0;
         powered_down_r <= 1'b0;
      end else begin
         rd_hit_r <= rd && addr == 4'hf;
         // card off, ports high, irq masked, then power-down
         if (rd_hit_r && rdata_r[7] === 1'b1) begin
            powered_down_r <= 1'b1;
         end
      end
   end
endmodule

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench;
   reg clk = 0, rstn = 0, wr = 0, rd = 0, pend = 0;
   reg [3:0] addr = 0;
   reg [7:0] wdata = 0;
   reg pin_n = 1, vccf = 0, rstf = 0, drop = 0, heat = 0, pres = 0;
   wire [7:0] rdata_r;
   wire int_n, sc, sd, por, pdown;
   integer n_mismatch = 0, check_count = 0, seed = 32'h17b5_ef07, k, sc_cnt = 0, sc_base = 0;
   reg [7:0] expq[$];
   always #2 clk = ~clk;
   chs_status #(.POR_CYCLES(8)) DUT (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata_r(rdata_r), .shutdown_request_pin_n(pin_n),
      .vcc_prot_fault(vccf), .rst_prot_fault(rstf), .supply_dropout(drop), .overheat(heat),
      .card_presence(pres), .interrupt_out_n_r(int_n), .start_clear_r(sc),
      .shutdown_mode_r(sd), .por_pulse_active_r(por));
   chs_fw_model fw (.clk(clk), .rstn(rstn), .rd(rd), .addr(addr), .rdata_r(rdata_r),
      .powered_down_r(pdown));
   always @(posedge clk) if (sc === 1'b1) sc_cnt <= sc_cnt + 1;
   // ====
   // read data monitor, one cycle after each strobe
   always @(negedge clk) begin
      if (pend) begin
         check_count++;
         if (rdata_r !== expq[0]) begin
            n_mismatch++;
            $display("[ERR] %0t read %h expected %h", $time, rdata_r, expq[0]);
         end
         void'(expq.pop_front());
      end
      pend = rd;
   end
   // ====
   // tasks
   task complete_run;
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input bit ok, input string m);
      check_count++;
      if (!ok) begin
         n_mismatch++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   // gap after each read lets the clear land
   task rd_reg(input [3:0] a, input [7:0] e);
      expq.push_back(e);
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      repeat (3) @(posedge clk);
   endtask
   // 0: pulse over, 1: in shutdown, 2: out of shutdown
   task wt(input integer c);
      integer i;
      for (i = 0; i < 40 && !(c == 0 ? por === 1'b0 : c == 1 ? sd === 1'b1 : sd === 1'b0); i++)
         @(posedge clk);
      if (i == 40) begin
         chk(0, "timeout");
         complete_run;
      end
   endtask
   task do_reset;
      rstn <= 0;
      repeat (4) @(posedge clk);
      rstn <= 1;
      @(posedge clk);
   endtask
   // ====
   // main sequence
   initial begin
      do_reset;
      chk(int_n === 1'b0 && por === 1'b1, "no pulse at power-on");
      rd_reg(4'hf, 8'h10);
      wt(0);
      @(posedge clk);
      chk(int_n === 1'b1, "interrupt after pulse");
      rd_reg(4'hf, 8'h10);
      rd_reg(4'hf, 8'h00);
      rd_reg({1'b0, 3'($random(seed))}, 8'h00);
      addr <= 4'hf;
      wdata <= 8'($random(seed));
      wr <= 1;
      @(posedge clk);
      wr <= 0;
      rd_reg(4'hf, 8'h00);
      for (k = 0; k < 5; k++) begin
         sc_base = sc_cnt;
         vccf <= k == 0;
         rstf <= k == 1;
         heat <= k == 2;
         if (k > 2) pres <= ~pres;
         repeat (10) @(posedge clk);
         chk(int_n === 1'b0 && sc_cnt != sc_base, "event");
         vccf <= 0;
         rstf <= 0;
         heat <= 0;
         repeat (10) @(posedge clk);
         rd_reg(4'hf, k < 2 ? 8'h20 : k == 2 ? 8'h01 : 8'h04);
         rd_reg(4'hf, 8'h00);
         chk(int_n === 1'b1, "interrupt after clear");
      end
      sc_base = sc_cnt;
      drop <= 1;
      repeat (12) @(posedge clk);
      chk(por === 1'b1 && int_n === 1'b0 && sc_cnt != sc_base, "dropout");
      rd_reg(4'hf, 8'h10);
      drop <= 0;
      wt(0);
      rd_reg(4'hf, 8'h10);
      rd_reg(4'hf, 8'h00);
      pin_n <= 0;
      wt(1);
      rd_reg(4'hf, 8'h80);
      chk(int_n === 1'b0 && pdown === 1'b1, "shutdown");
      repeat (20) @(posedge clk);
      chk(sd === 1'b1, "left shutdown early");
      pin_n <= 1;
      wt(2);
      repeat (2) @(posedge clk);
      chk(por === 1'b1 && int_n === 1'b0, "exit");
      wt(0);
      rd_reg(4'hf, 8'h90);
      rd_reg(4'hf, 8'h00);
      pin_n <= 0;
      do_reset;
      repeat (20) @(posedge clk);
      chk(int_n === 1'b0, "power-on with pin low");
      rd_reg(4'hf, 8'h90);
      chk(pdown === 1'b1, "firmware not down");
      complete_run;
   end
endmodule
